// ---- dsau_pkg.sv ----
// package: constants and types for the data-space access unit
package dsau_pkg;
  localparam int          DSAU_AW          = 16;
  localparam int          DSAU_DW          = 16;
  localparam logic [15:0] DSAU_SPECIAL_LAST = 16'h0FFF;
  localparam logic [15:0] DSAU_NEAR_LAST   = 16'h1FFF;
  localparam logic [15:0] DSAU_RAM_FIRST   = 16'h1000;
  localparam logic [15:0] DSAU_RAM_LAST    = 16'h3FFF;
  localparam logic [15:0] DSAU_XY_BOUNDARY = 16'h2800;
  localparam logic [15:0] DSAU_STEP_BYTE   = 16'h0001;
  localparam logic [15:0] DSAU_STEP_WORD   = 16'h0002;
  localparam int          DSAU_WIN_BIT     = 15;

  typedef enum logic [1:0] {
    DSAU_RGN_SPECIAL,
    DSAU_RGN_RAM,
    DSAU_RGN_WIN,
    DSAU_RGN_NONE
  } dsau_rgn_e;

  typedef enum logic [1:0] {
    DSAU_AM_PLAIN,
    DSAU_AM_MODULO,
    DSAU_AM_BITREV
  } dsau_amode_e;
endpackage

// ---- dsau_agu_if.sv ----
// interface: request and answer between access unit and one address generator
`timescale 1ns/10ps
interface dsau_addr_gen_if;
  import dsau_pkg::*;
  logic [15:0] ptr;
  logic        byte_op;
  logic        post_inc;
  dsau_amode_e amode;
  logic [15:0] mod_start;
  logic [15:0] mod_end;
  logic [15:0] rev_step;
  logic [15:0] addr;
  logic [15:0] ptr_next;
  modport core (output ptr, byte_op, post_inc, amode, mod_start, mod_end, rev_step,
                input addr, ptr_next);
  modport gen (input ptr, byte_op, post_inc, amode, mod_start, mod_end, rev_step,
               output addr, ptr_next);
endinterface

// ---- dsau_agu.sv ----
// module: address generator, pointer post-update with modulo and bit-reverse
`timescale 1ns/10ps
module dsau_addr_gen
  import dsau_pkg::*;
#(
  parameter bit ALLOW_BITREV = 1'b0
) (
  dsau_addr_gen_if.gen io
);
  logic [15:0] step;
  logic [15:0] sum;
  logic [15:0] rev;
  logic        carry;

  always_comb begin
    step  = io.byte_op ? DSAU_STEP_BYTE : DSAU_STEP_WORD;
    sum   = io.ptr + step;
    rev   = io.ptr;
    carry = 1'b0;
    // bit-reverse add: carry runs from the top bit down through every lower bit
    for (int b = 15; b >= 0; b--) begin
      rev[b] = io.ptr[b] ^ io.rev_step[b] ^ carry;
      carry  = (io.ptr[b] & io.rev_step[b]) | (carry & (io.ptr[b] ^ io.rev_step[b]));
    end
    io.addr     = io.ptr;
    io.ptr_next = io.ptr;
    if (io.post_inc) begin
      unique case (io.amode)
        DSAU_AM_MODULO: io.ptr_next = (io.ptr >= io.mod_end) ? io.mod_start : sum;
        DSAU_AM_BITREV: io.ptr_next = ALLOW_BITREV ? rev : sum;
        default:        io.ptr_next = sum;
      endcase
    end
  end
endmodule

// ---- dsau_top.sv ----
// top: data-space decode, lanes, misaligned trap and dual read paths
`timescale 1ns/10ps
module dsau_top
  import dsau_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // read side
  input  wire logic        i_rd_req,
  input  wire logic        i_rd_byte,
  input  wire logic        i_rd_direct,
  input  wire logic        i_rd_near,
  input  wire logic [15:0] i_rd_direct_addr,
  input  wire logic [15:0] i_rd_ptr,
  input  wire logic        i_rd_post_inc,
  input  wire logic [1:0]  i_rd_amode,
  input  wire logic [15:0] i_xmod_start,
  input  wire logic [15:0] i_xmod_end,
  // y path
  input  wire logic        i_y_req,
  input  wire logic [15:0] i_y_ptr,
  input  wire logic        i_y_post_inc,
  input  wire logic [1:0]  i_y_amode,
  input  wire logic [15:0] i_ymod_start,
  input  wire logic [15:0] i_ymod_end,
  // write side
  input  wire logic        i_wr_req,
  input  wire logic        i_wr_byte,
  input  wire logic        i_wr_direct,
  input  wire logic [15:0] i_wr_direct_addr,
  input  wire logic [15:0] i_wr_ptr,
  input  wire logic        i_wr_post_inc,
  input  wire logic [1:0]  i_wr_amode,
  input  wire logic [15:0] i_wr_rev_step,
  input  wire logic [15:0] i_wr_data,
  // instruction completion and register ops
  input  wire logic        i_instr_done,
  input  wire logic        i_sign_widen_op,
  input  wire logic        i_clear_upper_byte_op,
  input  wire logic [15:0] i_wreg_old,
  // memory side
  input  wire logic [15:0] i_mem_rdata,
  input  wire logic [15:0] i_mem_y_rdata,
  input  wire logic        i_special_hit,
  input  wire logic [15:0] i_special_rdata,
  input  wire logic [15:0] i_win_rdata,
  output logic      [14:0] o_mem_raddr,
  output logic      [14:0] o_mem_y_raddr,
  output logic      [14:0] o_mem_waddr,
  output logic      [1:0]  o_mem_we,
  output logic      [15:0] o_mem_wdata,
  output logic             o_win_rd,
  output logic      [14:0] o_win_addr,
  // core side
  output logic      [15:0] o_rd_ptr_next,
  output logic      [15:0] o_y_ptr_next,
  output logic      [15:0] o_wr_ptr_next,
  output logic      [15:0] o_x_rdata,
  output logic      [15:0] o_y_rdata,
  output logic      [15:0] o_wreg_new,
  output logic             o_addr_err_trap
);
  // ----------------------------------------------------------------
  // address generators
  // ----------------------------------------------------------------
  dsau_addr_gen_if rd_if ();
  dsau_addr_gen_if y_if ();
  dsau_addr_gen_if wr_if ();

  assign rd_if.ptr       = i_rd_ptr;
  assign rd_if.byte_op   = i_rd_byte;
  assign rd_if.post_inc  = i_rd_post_inc;
  assign rd_if.amode     = (i_rd_amode == 2'h1) ? DSAU_AM_MODULO : DSAU_AM_PLAIN;
  assign rd_if.mod_start = i_xmod_start;
  assign rd_if.mod_end   = i_xmod_end;
  assign rd_if.rev_step  = 16'h0000;
  assign y_if.ptr        = i_y_ptr;
  assign y_if.byte_op    = 1'b0;
  assign y_if.post_inc   = i_y_post_inc;
  assign y_if.amode      = (i_y_amode == 2'h1) ? DSAU_AM_MODULO : DSAU_AM_PLAIN;
  assign y_if.mod_start  = i_ymod_start;
  assign y_if.mod_end    = i_ymod_end;
  assign y_if.rev_step   = 16'h0000;
  assign wr_if.ptr       = i_wr_ptr;
  assign wr_if.byte_op   = i_wr_byte;
  assign wr_if.post_inc  = i_wr_post_inc;
  assign wr_if.mod_start = i_xmod_start;
  assign wr_if.mod_end   = i_xmod_end;
  assign wr_if.rev_step  = i_wr_rev_step;
  always_comb begin
    unique case (i_wr_amode)
      2'h1:    wr_if.amode = DSAU_AM_MODULO;
      2'h2:    wr_if.amode = DSAU_AM_BITREV;
      default: wr_if.amode = DSAU_AM_PLAIN;
    endcase
  end

  // independent generators for read and write
  dsau_addr_gen #(.ALLOW_BITREV(1'b0)) u_rd_gen (.io(rd_if));
  dsau_addr_gen #(.ALLOW_BITREV(1'b0)) u_y_gen  (.io(y_if));
  dsau_addr_gen #(.ALLOW_BITREV(1'b1)) u_wr_gen (.io(wr_if));

  assign o_rd_ptr_next = rd_if.ptr_next;
  assign o_y_ptr_next  = y_if.ptr_next;
  assign o_wr_ptr_next = wr_if.ptr_next;

  // ----------------------------------------------------------------
  // effective addresses and decode
  // ----------------------------------------------------------------
  logic [15:0] rd_addr;
  logic [15:0] wr_addr;
  logic [15:0] y_addr;
  dsau_rgn_e   rd_rgn;
  dsau_rgn_e   wr_rgn;

  function automatic dsau_rgn_e decode(input logic [15:0] addr);
    if (addr[DSAU_WIN_BIT]) begin
      decode = DSAU_RGN_WIN;
    end else if (addr <= DSAU_SPECIAL_LAST) begin
      decode = DSAU_RGN_SPECIAL;
    end else if (addr <= DSAU_RAM_LAST) begin
      decode = DSAU_RGN_RAM;
    end else begin
      decode = DSAU_RGN_NONE;
    end
  endfunction

  always_comb begin
    // near field is 13 bits, full direct field 16 bits
    if (i_rd_direct) begin
      rd_addr = i_rd_near ? {3'h0, i_rd_direct_addr[12:0]} : i_rd_direct_addr;
    end else begin
      rd_addr = rd_if.addr;
    end
    wr_addr = i_wr_direct ? i_wr_direct_addr : wr_if.addr;
    y_addr  = y_if.addr;
    rd_rgn  = decode(rd_addr);
    wr_rgn  = decode(wr_addr);
  end

  // ----------------------------------------------------------------
  // misalignment and write lanes
  // ----------------------------------------------------------------
  logic rd_mis;
  logic wr_mis;
  assign rd_mis = i_rd_req && !i_rd_byte && rd_addr[0];
  assign wr_mis = i_wr_req && !i_wr_byte && wr_addr[0];

  logic [1:0]  we_d;
  logic [15:0] wdata_d;
  always_comb begin
    we_d    = 2'b00;
    wdata_d = i_wr_data;
    if (i_wr_req && !wr_mis && wr_rgn == DSAU_RGN_RAM) begin
      if (i_wr_byte) begin
        we_d    = wr_addr[0] ? 2'b10 : 2'b01;
        wdata_d = {i_wr_data[7:0], i_wr_data[7:0]};
      end else begin
        we_d = 2'b11;
      end
    end
  end

  assign o_mem_raddr   = rd_addr[15:1];
  assign o_mem_y_raddr = y_addr[15:1];
  assign o_win_addr    = rd_addr[14:0];
  assign o_win_rd      = i_rd_req && rd_rgn == DSAU_RGN_WIN;

  // ----------------------------------------------------------------
  // registered stage: write strobes, read select, trap pending
  // ----------------------------------------------------------------
  logic [14:0] waddr_q, waddr_d;
  logic [1:0]  we_q;
  logic [15:0] wdata_q;
  logic        rd_byte_q, rd_byte_d;
  logic        rd_hi_q, rd_hi_d;
  dsau_rgn_e   rd_rgn_q, rd_rgn_d;
  logic        y_ok_q, y_ok_d;
  logic        pend_q, pend_d;
  logic        trap_q, trap_d;

  always_comb begin
    waddr_d   = wr_addr[15:1];
    rd_byte_d = i_rd_byte;
    rd_hi_d   = rd_addr[0];
    rd_rgn_d  = i_rd_req ? rd_rgn : DSAU_RGN_NONE;
    y_ok_d    = i_y_req && !y_addr[DSAU_WIN_BIT] && y_addr >= DSAU_XY_BOUNDARY &&
                y_addr <= DSAU_RAM_LAST;
    // fault stays pending until the instruction completes
    pend_d    = pend_q || rd_mis || wr_mis;
    trap_d    = 1'b0;
    if (i_instr_done && pend_d) begin
      trap_d = 1'b1;
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      waddr_q   <= 15'h0000;
      we_q      <= 2'h0;
      wdata_q   <= 16'h0000;
      rd_byte_q <= 1'b0;
      rd_hi_q   <= 1'b0;
      rd_rgn_q  <= DSAU_RGN_NONE;
      y_ok_q    <= 1'b0;
      pend_q    <= 1'b0;
      trap_q    <= 1'b0;
    end else begin
      waddr_q   <= waddr_d;
      we_q      <= we_d;
      wdata_q   <= wdata_d;
      rd_byte_q <= rd_byte_d;
      rd_hi_q   <= rd_hi_d;
      rd_rgn_q  <= rd_rgn_d;
      y_ok_q    <= y_ok_d;
      pend_q    <= pend_d;
      trap_q    <= trap_d;
    end
  end

  assign o_mem_waddr     = waddr_q;
  assign o_mem_we        = we_q;
  assign o_mem_wdata     = wdata_q;
  assign o_addr_err_trap = trap_q;

  // ----------------------------------------------------------------
  // read data return, one cycle after request
  // ----------------------------------------------------------------
  logic [15:0] word;
  always_comb begin
    unique case (rd_rgn_q)
      DSAU_RGN_SPECIAL: word = i_special_hit ? i_special_rdata : 16'h0000;
      DSAU_RGN_RAM: word = i_mem_rdata;
      DSAU_RGN_WIN: word = i_win_rdata;
      default:      word = 16'h0000;
    endcase
    // byte reads land in low byte
    if (rd_byte_q) begin
      o_x_rdata = {8'h00, rd_hi_q ? word[15:8] : word[7:0]};
    end else begin
      o_x_rdata = word;
    end
    o_y_rdata = y_ok_q ? i_mem_y_rdata : 16'h0000;
    // register write-back shaping
    if (i_sign_widen_op) begin
      o_wreg_new = {{8{i_wreg_old[7]}}, i_wreg_old[7:0]};
    end else if (i_clear_upper_byte_op) begin
      o_wreg_new = {8'h00, i_wreg_old[7:0]};
    end else if (rd_byte_q) begin
      o_wreg_new = {i_wreg_old[15:8], o_x_rdata[7:0]};
    end else begin
      o_wreg_new = o_x_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  wr_suppress_a: assert property (wr_mis |=> we_q == 2'b00)
    else $error("misaligned write reached memory");
  byte_lane_a: assert property (i_wr_req && i_wr_byte && wr_rgn == DSAU_RGN_RAM
      |=> we_q == ($past(wr_addr[0]) ? 2'b10 : 2'b01))
    else $error("byte write lane wrong");
  trap_pulse_a: assert property (trap_q |=> !trap_q)
    else $error("trap longer than one cycle");
  trap_cause_a: assert property ((rd_mis || wr_mis) && i_instr_done |=> trap_q)
    else $error("misaligned access gave no trap");
  trap_wait_a: assert property (trap_q |-> $past(i_instr_done))
    else $error("trap before completion");
  byte_zero_a: assert property (i_rd_req && i_rd_byte |=> o_x_rdata[15:8] == 8'h00)
    else $error("byte read high lane not zero");
  unimpl_zero_a: assert property (i_rd_req && rd_rgn == DSAU_RGN_NONE
      |=> o_x_rdata == 16'h0000)
    else $error("unimplemented read not zero");
  post_inc_a: assert property (i_rd_post_inc && rd_if.amode == DSAU_AM_PLAIN
      |-> o_rd_ptr_next == i_rd_ptr + (i_rd_byte ? 16'h0001 : 16'h0002))
    else $error("pointer step wrong");
  byte_load_a: assert property (rd_byte_q && !i_sign_widen_op && !i_clear_upper_byte_op
      |-> o_wreg_new[15:8] == i_wreg_old[15:8])
    else $error("byte load touched high byte");
  win_route_a: assert property (i_rd_req && rd_addr[15] |-> o_win_rd)
    else $error("window read not routed");

  trap_cov: cover property (wr_mis ##[1:4] trap_q);
  byte_wr_cov: cover property (i_wr_req && i_wr_byte && wr_addr[0]);
  dual_rd_cov: cover property (i_rd_req && i_y_req);
endmodule

// ---- dsau_mem_model.sv ----
// partner model: data RAM, special register array and program window
`timescale 1ns/10ps
module dsau_mem_model (
  input  wire logic        i_clk,
  input  wire logic [14:0] i_raddr,
  input  wire logic [14:0] i_y_raddr,
  input  wire logic [14:0] i_waddr,
  input  wire logic [1:0]  i_we,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_win_rd,
  output logic      [15:0] o_rdata,
  output logic      [15:0] o_y_rdata,
  output logic             o_special_hit,
  output logic      [15:0] o_special_rdata,
  output logic      [15:0] o_win_rdata
);
  logic [15:0] mem [0:32767];

  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 16'h0000;
    {o_rdata, o_y_rdata, o_special_rdata, o_win_rdata, o_special_hit} = '0;
  end

  // ------
  // memory side, answers the address of the previous cycle
  // ------
  always @(posedge i_clk) begin
    if (i_we[0]) mem[i_waddr][7:0] <= i_wdata[7:0];
    if (i_we[1]) mem[i_waddr][15:8] <= i_wdata[15:8];
    o_rdata <= mem[i_raddr];
    o_y_rdata <= mem[i_y_raddr];
    // only the first 256 bytes hold registers; elsewhere data toggles so a leak shows
    o_special_hit <= (i_raddr < 15'h0080);
    o_special_rdata <= (i_raddr < 15'h0080) ? {~i_raddr[7:0], i_raddr[7:0]} : ~o_special_rdata;
    o_win_rdata <= i_win_rd ? 16'hC35A : ~o_win_rdata;
  end
endmodule

// ---- dsau_top_tb.sv ----
// testbench: data-space access unit against the memory-side model
`timescale 1ns/10ps
module dsau_top_tb
  import dsau_pkg::*;
;
  logic        i_clk, i_rst_n, i_rd_req, i_rd_byte, i_rd_direct, i_rd_near, i_rd_post_inc;
  logic        i_y_req, i_y_post_inc, i_wr_req, i_wr_byte, i_wr_direct, i_wr_post_inc;
  logic        i_instr_done, i_sign_widen_op, i_clear_upper_byte_op, i_special_hit, o_win_rd;
  logic        o_addr_err_trap, b;
  logic [1:0]  i_rd_amode, i_y_amode, i_wr_amode, o_mem_we;
  logic [14:0] o_mem_raddr, o_mem_y_raddr, o_mem_waddr, o_win_addr;
  logic [15:0] i_rd_direct_addr, i_rd_ptr, i_xmod_start, i_xmod_end, i_y_ptr, i_ymod_start;
  logic [15:0] i_ymod_end, i_wr_direct_addr, i_wr_ptr, i_wr_rev_step, i_wr_data, i_wreg_old;
  logic [15:0] i_mem_rdata, i_mem_y_rdata, i_special_rdata, i_win_rdata, o_mem_wdata, a, r, d, v;
  logic [15:0] o_rd_ptr_next, o_y_ptr_next, o_wr_ptr_next, o_x_rdata, o_y_rdata, o_wreg_new;
  logic [15:0] shadow [0:32767];
  int          failures, checked, cycles;
  logic [15:0] wa [6] = '{16'h1000, 16'h3FFE, 16'h0FFE, 16'h4000, 16'h3FFF, 16'h8000};
  logic [15:0] ra [8] = '{16'h0000, 16'h00FE, 16'h0100, 16'h0FFF, 16'h1FFE, 16'h4000,
                          16'h7FFE, 16'hFFFE};

  dsau_top dut (
    .i_clk, .i_rst_n, .i_rd_req, .i_rd_byte, .i_rd_direct, .i_rd_near, .i_rd_direct_addr,
    .i_rd_ptr, .i_rd_post_inc, .i_rd_amode, .i_xmod_start, .i_xmod_end, .i_y_req, .i_y_ptr,
    .i_y_post_inc, .i_y_amode, .i_ymod_start, .i_ymod_end, .i_wr_req, .i_wr_byte,
    .i_wr_direct, .i_wr_direct_addr, .i_wr_ptr, .i_wr_post_inc, .i_wr_amode, .i_wr_rev_step,
    .i_wr_data, .i_instr_done, .i_sign_widen_op, .i_clear_upper_byte_op, .i_wreg_old,
    .i_mem_rdata, .i_mem_y_rdata, .i_special_hit, .i_special_rdata, .i_win_rdata, .o_mem_raddr,
    .o_mem_y_raddr, .o_mem_waddr, .o_mem_we, .o_mem_wdata, .o_win_rd, .o_win_addr,
    .o_rd_ptr_next, .o_y_ptr_next, .o_wr_ptr_next, .o_x_rdata, .o_y_rdata, .o_wreg_new,
    .o_addr_err_trap
  );
  dsau_mem_model mdl (
    .i_clk, .i_raddr (o_mem_raddr), .i_y_raddr (o_mem_y_raddr), .i_waddr (o_mem_waddr),
    .i_we (o_mem_we), .i_wdata (o_mem_wdata), .i_win_rd (o_win_rd), .o_rdata (i_mem_rdata),
    .o_y_rdata (i_mem_y_rdata), .o_special_hit (i_special_hit),
    .o_special_rdata (i_special_rdata), .o_win_rdata (i_win_rdata)
  );

  // ------
  // expectations and checks
  // ------
  function automatic logic [15:0] exp_rd(input logic [15:0] ad, input logic bt);
    logic [15:0] w;
    if (ad[15]) w = 16'hC35A;
    else if (ad < DSAU_RAM_FIRST) w = (ad[15:8] == 8'h00) ? {~ad[8:1], ad[8:1]} : 16'h0000;
    else if (ad <= DSAU_RAM_LAST) w = shadow[ad[15:1]];
    else w = 16'h0000;
    return bt ? {8'h00, ad[0] ? w[15:8] : w[7:0]} : w;
  endfunction

  function automatic logic [1:0] exp_we(input logic [15:0] ad, input logic bt);
    if (ad < DSAU_RAM_FIRST || ad > DSAU_RAM_LAST || (!bt && ad[0])) return 2'b00;
    return bt ? (ad[0] ? 2'b10 : 2'b01) : 2'b11;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // mode 0 full direct, 1 near field, 2 pointer; request left high for back-to-back use
  task automatic rd(input logic [15:0] ad, input logic bt, input logic [1:0] m);
    logic [15:0] e;
    if (m == 2'd1 && ad > DSAU_NEAR_LAST) m = 2'd0;
    if (m == 2'd2 && ad[15]) m = 2'd0;
    e = exp_rd(ad, bt);
    i_rd_req = 1'b1;
    i_rd_byte = bt;
    i_rd_direct = (m != 2'd2);
    i_rd_near = (m == 2'd1);
    i_rd_direct_addr = (m == 2'd1) ? {3'b101, ad[12:0]} : ad;
    i_rd_ptr = ad;
    i_rd_post_inc = 1'($urandom);
    i_rd_amode = 2'($urandom % 2);
    i_wreg_old = 16'($urandom);
    #1;
    if (!ad[15]) chk(o_mem_raddr, ad[15:1]);
    else chk(o_win_addr, ad[14:0]);
    if (m == 2'd2) chk(o_rd_ptr_next, ad + (i_rd_post_inc ? (bt ? 16'h1 : 16'h2) : 16'h0));
    @(negedge i_clk);
    chk(o_x_rdata, e);
    chk(o_wreg_new, bt ? {i_wreg_old[15:8], e[7:0]} : e);
    chk(o_addr_err_trap, 1'b0);
  endtask

  task automatic wr(input logic [15:0] ad, input logic [15:0] dt, input logic bt,
                    input logic p);
    logic [1:0] e;
    e = exp_we(ad, bt);
    i_wr_req = 1'b1;
    i_wr_byte = bt;
    i_wr_direct = !p;
    i_wr_direct_addr = ad;
    i_wr_ptr = ad;
    i_wr_data = dt;
    i_wr_post_inc = 1'($urandom);
    i_wr_amode = 2'($urandom % 2);
    #1;
    if (p) chk(o_wr_ptr_next, ad + (i_wr_post_inc ? (bt ? 16'h1 : 16'h2) : 16'h0));
    @(negedge i_clk);
    chk(o_mem_we, e);
    chk(o_addr_err_trap, !bt && ad[0] && i_instr_done);
    if (e != 2'b00) chk(o_mem_waddr, ad[15:1]);
    if (e != 2'b00) chk(o_mem_wdata, bt ? {dt[7:0], dt[7:0]} : dt);
    if (e[0]) shadow[ad[15:1]][7:0] = dt[7:0];
    if (e[1]) shadow[ad[15:1]][15:8] = bt ? dt[7:0] : dt[15:8];
  endtask

  task automatic idle();
    {i_rd_req, i_wr_req, i_y_req, i_instr_done} = 4'h0;
    @(negedge i_clk);
  endtask

  // ------
  // stimulus
  // ------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    {i_rd_req, i_rd_byte, i_rd_direct, i_rd_near, i_rd_post_inc, i_y_req, i_y_post_inc} = '0;
    {i_wr_req, i_wr_byte, i_wr_direct, i_wr_post_inc, i_instr_done, i_sign_widen_op} = '0;
    {i_clear_upper_byte_op, i_rd_amode, i_y_amode, i_wr_amode, i_wreg_old} = '0;
    {i_rd_direct_addr, i_rd_ptr, i_y_ptr, i_wr_direct_addr, i_wr_ptr, i_wr_data} = '0;
    // modulo bounds span the whole space so only the plain step shows
    {i_xmod_start, i_ymod_start, i_xmod_end, i_ymod_end, i_wr_rev_step} = 80'hFFFF_FFFF_0001;
    for (int i = 0; i < 32768; i++) shadow[i] = 16'h0000;
    i_rst_n = 1'b0;
    v = 16'($urandom(85));
    repeat (6) @(negedge i_clk);
    i_rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(wa[i], 16'($urandom), wa[i][0], i[0]);
      idle();
    end
    for (int i = 0; i < 6; i++) rd(wa[i], wa[i][0], 2'd0);
    for (int i = 0; i < 8; i++) rd(ra[i], ra[i][0], 2'd1);
    idle();
    $display("test corners done");
    rd(16'h1234, 1'b0, 2'd0);
    {i_rd_req, i_instr_done} = 2'b01;
    chk(o_addr_err_trap, 1'b0);
    @(negedge i_clk);
    i_instr_done = 1'b0;
    chk(o_addr_err_trap, 1'b0);
    i_rd_req = 1'b1;
    i_rd_direct_addr = 16'h1235;
    @(negedge i_clk);
    i_rd_req = 1'b0;
    repeat (2) @(negedge i_clk) chk(o_addr_err_trap, 1'b0);
    i_instr_done = 1'b1;
    @(negedge i_clk);
    i_instr_done = 1'b0;
    chk(o_addr_err_trap, 1'b1);
    @(negedge i_clk);
    chk(o_addr_err_trap, 1'b0);
    i_instr_done = 1'b1;
    wr(16'h2001, 16'hDEAD, 1'b0, 1'b0);
    idle();
    chk(o_addr_err_trap, 1'b0);
    rd(16'h2000, 1'b0, 2'd0);
    idle();
    $display("test misaligned done");
    wr(16'h3000, 16'hBEEF, 1'b0, 1'b0);
    idle();
    wr(16'h2000, 16'h1234, 1'b0, 1'b0);
    idle();
    for (int i = 0; i < 2; i++) begin
      i_y_req = 1'b1;
      i_y_ptr = i[0] ? 16'h2000 : 16'h3000;
      i_y_post_inc = !i[0];
      i_y_amode = 2'($urandom % 2);
      #1;
      chk(o_mem_y_raddr, i_y_ptr[15:1]);
      chk(o_y_ptr_next, i_y_ptr + (i[0] ? 16'h0 : 16'h2));
      rd(16'h1000, 1'b0, 2'd2);
      chk(o_y_rdata, i[0] ? 16'h0000 : 16'hBEEF);
    end
    idle();
    $display("test dual read done");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 16'h1280 : (i == 1) ? 16'hFF7F : 16'($urandom);
      i_wreg_old = v;
      i_sign_widen_op = 1'b1;
      #1;
      chk(o_wreg_new, {{8{v[7]}}, v[7:0]});
      i_sign_widen_op = 1'b0;
      i_clear_upper_byte_op = 1'b1;
      #1;
      chk(o_wreg_new, {8'h00, v[7:0]});
      i_clear_upper_byte_op = 1'b0;
      @(negedge i_clk);
    end
    $display("test register ops done");
    // modulo wrap on both read generators, reverse carry on the write one
    {i_xmod_start, i_xmod_end, i_ymod_start, i_ymod_end} = 64'h1100_11FE_2800_2FFE;
    {i_rd_ptr, i_y_ptr, i_wr_ptr, i_wr_rev_step} = 64'h11FE_2FFE_1008_0008;
    {i_rd_post_inc, i_y_post_inc, i_wr_post_inc, i_rd_byte} = 4'hE;
    {i_rd_amode, i_y_amode, i_wr_amode} = 6'b01_01_10;
    #1;
    chk(o_rd_ptr_next, 16'h1100);
    chk(o_y_ptr_next, 16'h2800);
    chk(o_wr_ptr_next, 16'h1004);
    {i_wr_ptr, i_rd_amode} = {16'h1004, 2'h2};
    #1;
    chk(o_wr_ptr_next, 16'h100C);
    chk(o_rd_ptr_next, 16'h1200);
    {i_xmod_start, i_xmod_end, i_ymod_start, i_ymod_end} = 64'h0000_FFFF_0000_FFFF;
    {i_wr_amode, i_wr_rev_step} = 18'h00001;
    @(negedge i_clk);
    $display("test pointer modes done");
    for (int i = 0; i < 80; i++) begin
      a = DSAU_RAM_FIRST + 16'($urandom % 32'h3000);
      b = 1'($urandom);
      if (!b) a[0] = 1'b0;
      d = 16'($urandom);
      wr(a, d, b, 1'($urandom));
      idle();
      rd(a, b, 2'($urandom % 3));
      r = 16'($urandom);
      b = 1'($urandom);
      if (!b) r[0] = 1'b0;
      rd(r, b, 2'($urandom % 3));
    end
    idle();
    $display("test random done");
    finish_test();
  end
endmodule
